// file: hdl/tweep_target.sv
// Two-wire EEPROM target protocol engine with internal array
`timescale 1ns/1ps
`include "tweep_defs.svh"
module tweep_target #(
    parameter logic [1:0] VARIANT = `TWEEP_VAR_2K,
    parameter int WR_CYCLES = `TWEEP_WR_CYCLES
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // Two-wire link
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Hard-wired select pins
    input wire logic select_pin_high,
    input wire logic select_pin_mid,
    input wire logic select_pin_low,
    // Status
    output logic busy
);
    localparam int AW = (VARIANT == `TWEEP_VAR_2K) ? 8 : (VARIANT == `TWEEP_VAR_4K) ? 9 : 10;
    localparam int PB = (VARIANT == `TWEEP_VAR_2K) ? 3 : 4;
    localparam int PAGE = 1 << PB;
    localparam int DEPTH = 1 << AW;

    // ==========================================================
    // Synchronisers and edge detection
    logic [1:0] scl_sync, sda_sync;
    logic scl_d, sda_d;
    // Straps are pins as well; sampled twice before the match logic reads them
    logic [2:0] sel_meta, sel_pins;
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            scl_sync <= 2'h3;
            sda_sync <= 2'h3;
            scl_d <= 1'b1;
            sda_d <= 1'b1;
            sel_meta <= 3'h0;
            sel_pins <= 3'h0;
        end else begin
            scl_sync <= {scl_sync[0], scl_in};
            sda_sync <= {sda_sync[0], sda_in};
            scl_d <= scl_sync[1];
            sda_d <= sda_sync[1];
            sel_meta <= {select_pin_high, select_pin_mid, select_pin_low};
            sel_pins <= sel_meta;
        end
    end
    wire scl_s = scl_sync[1];
    wire sda_s = sda_sync[1];
    wire scl_rise = scl_s && !scl_d;
    wire scl_fall = !scl_s && scl_d;
    wire start_det = scl_s && scl_d && sda_d && !sda_s;
    wire stop_det = scl_s && scl_d && !sda_d && sda_s;

    // ==========================================================
    // Address match per size variant
    function automatic logic dev_match(input logic [7:0] w);
        logic ok;
        ok = (w[7:4] == `TWEEP_DEV_CODE);
        ok = ok && (w[3] == sel_pins[2]);
        if (VARIANT != `TWEEP_VAR_8K)
            ok = ok && (w[2] == sel_pins[1]);
        if (VARIANT == `TWEEP_VAR_2K)
            ok = ok && (w[1] == sel_pins[0]);
        return ok;
    endfunction

    // ==========================================================
    // Protocol state
    tweep_pkg::tweep_state_t state;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic ack_phase;
    logic [AW-1:0] addr;
    logic [7:0] mem [DEPTH];
    logic [31:0] wr_cnt;
    logic [1:0] page_bits;

    always_comb begin
        page_bits = 2'h0;
        if (VARIANT == `TWEEP_VAR_8K)
            page_bits = shreg[2:1];
        else if (VARIANT == `TWEEP_VAR_4K)
            page_bits = {1'b0, shreg[1]};
    end

    wire byte_done = scl_rise && !ack_phase && (bitcnt == 4'h7);
    wire [7:0] rx_byte = {shreg[6:0], sda_s};
    wire [AW-1:0] wr_next = {addr[AW-1:PB], addr[PB-1:0] + 1'b1};
    wire [AW-1:0] rd_next = addr + 1'b1;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= tweep_pkg::TWEEP_IDLE;
            bitcnt <= 4'h0;
            shreg <= 8'h00;
            ack_phase <= 1'b0;
        end else if (busy) begin
            state <= tweep_pkg::TWEEP_IDLE;
        end else if (start_det) begin
            state <= tweep_pkg::TWEEP_DEVADR;
            bitcnt <= 4'h0;
            ack_phase <= 1'b0;
        end else if (stop_det) begin
            state <= tweep_pkg::TWEEP_IDLE;
        end else if (state != tweep_pkg::TWEEP_IDLE) begin
            if (state == tweep_pkg::TWEEP_RDATA) begin
                if (scl_rise && ack_phase && sda_s)
                    state <= tweep_pkg::TWEEP_IDLE;
                if (scl_fall && ack_phase) begin
                    ack_phase <= 1'b0;
                    bitcnt <= 4'h0;
                    shreg <= mem[addr];
                end else if (scl_fall && !ack_phase) begin
                    if (bitcnt == 4'h8) begin
                        ack_phase <= 1'b1;
                    end
                end else if (scl_rise && !ack_phase) begin
                    bitcnt <= bitcnt + 4'h1;
                    shreg <= {shreg[6:0], 1'b1};
                end
            end else if (byte_done) begin
                shreg <= rx_byte;
                bitcnt <= 4'h8;
            end else if (scl_rise && !ack_phase) begin
                shreg <= rx_byte;
                bitcnt <= bitcnt + 4'h1;
            end else if (scl_fall && bitcnt == 4'h8 && !ack_phase) begin
                if (state == tweep_pkg::TWEEP_DEVADR && !dev_match(shreg))
                    state <= tweep_pkg::TWEEP_IDLE;
                else
                    ack_phase <= 1'b1;
            end else if (scl_fall && ack_phase) begin
                ack_phase <= 1'b0;
                bitcnt <= 4'h0;
                if (state == tweep_pkg::TWEEP_DEVADR) begin
                    if (shreg[0]) begin
                        state <= tweep_pkg::TWEEP_RDATA;
                        shreg <= mem[addr];
                    end else begin
                        state <= tweep_pkg::TWEEP_WORDADR;
                    end
                end else if (state == tweep_pkg::TWEEP_WORDADR) begin
                    state <= tweep_pkg::TWEEP_WDATA;
                end
            end
        end
    end

    // ==========================================================
    // Address counter and page buffer
    logic [7:0] pbuf [PAGE];
    logic [PAGE-1:0] pvalid;
    logic [AW-1:0] page_base;
    logic [1:0] dev_page;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            addr <= '0;
            pvalid <= '0;
            page_base <= '0;
            dev_page <= 2'h0;
        end else if (!busy) begin
            if (state == tweep_pkg::TWEEP_DEVADR && scl_fall && bitcnt == 4'h8 && !ack_phase
                && dev_match(shreg)) begin
                dev_page <= page_bits;
                if (AW > 8)
                    addr <= AW'({page_bits, addr[7:0]});
            end
            if (state == tweep_pkg::TWEEP_WORDADR && byte_done) begin
                addr <= AW'({dev_page, rx_byte});
                page_base <= AW'({dev_page, rx_byte});
                pvalid <= '0;
            end
            if (state == tweep_pkg::TWEEP_WDATA && byte_done) begin
                pbuf[addr[PB-1:0]] <= rx_byte;
                pvalid[addr[PB-1:0]] <= 1'b1;
                addr <= wr_next;
            end
            // Advance once the byte is out, so a NACKed last byte still counts
            if (state == tweep_pkg::TWEEP_RDATA && scl_fall && !ack_phase && bitcnt == 4'h8)
                addr <= rd_next;
        end
    end

    // ==========================================================
    // Self-timed write cycle; array committed at its start
    always_ff @(posedge core_clk) begin
        if (!busy && stop_det && state == tweep_pkg::TWEEP_WDATA) begin
            for (int i = 0; i < PAGE; i++) begin
                if (pvalid[i])
                    mem[{page_base[AW-1:PB], PB'(i)}] <= pbuf[i];
            end
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            busy <= 1'b0;
            wr_cnt <= 32'h0;
        end else if (busy) begin
            if (wr_cnt == 32'(WR_CYCLES - 1)) begin
                busy <= 1'b0;
                wr_cnt <= 32'h0;
            end else begin
                wr_cnt <= wr_cnt + 32'h1;
            end
        end else if (stop_det && state == tweep_pkg::TWEEP_WDATA && |pvalid) begin
            busy <= 1'b1;
        end
    end

    // ==========================================================
    // Open-drain SDA; low only on ack or zero data bit
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            sda_oe <= 1'b0;
            sda_out <= 1'b0;
        end else begin
            sda_out <= 1'b0;
            if (busy || start_det || stop_det)
                sda_oe <= 1'b0;
            else if (scl_fall) begin
                if (state == tweep_pkg::TWEEP_RDATA) begin
                    if (ack_phase)
                        sda_oe <= 1'b0;
                    else if (bitcnt == 4'h8)
                        sda_oe <= 1'b0;
                    else
                        sda_oe <= !shreg[7];
                end else if (bitcnt == 4'h8 && !ack_phase && state != tweep_pkg::TWEEP_IDLE
                    && (state != tweep_pkg::TWEEP_DEVADR || dev_match(shreg))) begin
                    sda_oe <= 1'b1;
                end else begin
                    sda_oe <= 1'b0;
                end
            end
            if (state == tweep_pkg::TWEEP_RDATA && scl_fall && ack_phase)
                sda_oe <= !mem[addr][7];
            if (state == tweep_pkg::TWEEP_DEVADR && scl_fall && ack_phase && shreg[0])
                sda_oe <= !mem[addr][7];
        end
    end

    // ==========================================================
    // Checks
    property p_ack_after_match;
        @(posedge core_clk) disable iff (!arst_n)
        (!busy && state == tweep_pkg::TWEEP_DEVADR && scl_fall && bitcnt == 4'h8
         && !ack_phase && dev_match(shreg) && !start_det && !stop_det) |=> sda_oe;
    endproperty
    a_ack_after_match: assert property (p_ack_after_match) else $error("no ack on match");
    property p_no_ack_busy;
        @(posedge core_clk) disable iff (!arst_n) busy |=> !sda_oe || !busy;
    endproperty
    a_no_ack_busy: assert property (p_no_ack_busy) else $error("drive while busy");
    property p_start_state;
        @(posedge core_clk) disable iff (!arst_n)
        (start_det && !busy) |=> state == tweep_pkg::TWEEP_DEVADR;
    endproperty
    a_start_state: assert property (p_start_state) else $error("start missed");
    property p_stop_idle;
        @(posedge core_clk) disable iff (!arst_n) stop_det |=> state == tweep_pkg::TWEEP_IDLE;
    endproperty
    a_stop_idle: assert property (p_stop_idle) else $error("stop missed");
    property p_drive_low;
        @(posedge core_clk) disable iff (!arst_n) sda_out == 1'b0;
    endproperty
    a_drive_low: assert property (p_drive_low) else $error("sda driven high");
    property p_page_wrap;
        @(posedge core_clk) disable iff (!arst_n)
        (!busy && state == tweep_pkg::TWEEP_WDATA && byte_done)
        |=> addr[AW-1:PB] == $past(addr[AW-1:PB]);
    endproperty
    a_page_wrap: assert property (p_page_wrap) else $error("page row changed");
    property p_busy_len;
        @(posedge core_clk) disable iff (!arst_n) $rose(busy) |-> busy [*8];
    endproperty
    a_busy_len: assert property (p_busy_len) else $error("write cycle short");
    property p_mismatch_idle;
        @(posedge core_clk) disable iff (!arst_n)
        (!busy && state == tweep_pkg::TWEEP_DEVADR && scl_fall && bitcnt == 4'h8
         && !ack_phase && !dev_match(shreg) && !start_det && !stop_det)
        |=> state == tweep_pkg::TWEEP_IDLE;
    endproperty
    a_mismatch_idle: assert property (p_mismatch_idle) else $error("mismatch kept");
    property p_read_advance;
        @(posedge core_clk) disable iff (!arst_n)
        (!busy && state == tweep_pkg::TWEEP_RDATA && scl_fall && !ack_phase && bitcnt == 4'h8)
        |=> addr == $past(addr) + 1'b1;
    endproperty
    a_read_advance: assert property (p_read_advance) else $error("read counter stuck");
    c_read: cover property (@(posedge core_clk) state == tweep_pkg::TWEEP_RDATA);
    c_write: cover property (@(posedge core_clk) $rose(busy));
    c_wordadr: cover property (@(posedge core_clk) state == tweep_pkg::TWEEP_WORDADR);
endmodule // tweep_target

// file: hdl/tweep_defs.svh
// Constants for the two-wire EEPROM target protocol block
`ifndef TWEEP_DEFS_SVH
`define TWEEP_DEFS_SVH
`define TWEEP_DEV_CODE 4'hA
`define TWEEP_CLK_PERIOD_NS 5
`define TWEEP_WR_TIME_MS 10
`define TWEEP_WR_CYCLES ((`TWEEP_WR_TIME_MS * 1000000) / `TWEEP_CLK_PERIOD_NS)
`define TWEEP_VAR_2K 2'h0
`define TWEEP_VAR_4K 2'h1
`define TWEEP_VAR_8K 2'h2
`endif

// file: hdl/tweep_pkg.sv
// Types for the two-wire EEPROM target protocol block
package tweep_pkg;
    typedef enum logic [2:0] {
        TWEEP_IDLE = 3'b000,
        TWEEP_DEVADR = 3'b001,
        TWEEP_WORDADR = 3'b010,
        TWEEP_WDATA = 3'b011,
        TWEEP_RDATA = 3'b100
    } tweep_state_t;
endpackage

// file: test/tweep_ctl_model.sv
// Two-wire bus controller model: drives SCL, pulls SDA open drain
`timescale 1ns/1ps
module tweep_ctl_model (
    // Clock
    input wire logic core_clk,
    // Two-wire link
    input wire logic sda_wire,
    output logic scl,
    output logic sda_pull
);
    // ==========================================
    // Bus primitives, 125 ns SCL period
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    task automatic wait_clk(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic start();
        sda_pull <= 1'b0;
        wait_clk(6);
        scl <= 1'b1;
        wait_clk(7);
        sda_pull <= 1'b1;
        wait_clk(6);
        scl <= 1'b0;
        wait_clk(6);
    endtask
    task automatic stop();
        sda_pull <= 1'b1;
        wait_clk(6);
        scl <= 1'b1;
        wait_clk(7);
        sda_pull <= 1'b0;
        wait_clk(12);
    endtask
    // Data moves only in the low half; sampled late in the high half
    task automatic xfer_bit(input logic b, output logic r);
        sda_pull <= !b;
        wait_clk(6);
        scl <= 1'b1;
        wait_clk(13);
        r = sda_wire;
        scl <= 1'b0;
        wait_clk(6);
    endtask
    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) xfer_bit(d[i], r);
        xfer_bit(1'b1, r);
        ack = !r;
    endtask
    task automatic recv_byte(input logic ack_it, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            xfer_bit(1'b1, r);
            d[i] = r;
        end
        xfer_bit(!ack_it, r);
    endtask
    // Clock out a stuck target, then start afresh
    task automatic recover();
        logic r;
        int n;
        n = 0;
        r = 1'b0;
        while (!r && n < 9) begin
            sda_pull <= 1'b0;
            wait_clk(6);
            scl <= 1'b1;
            wait_clk(13);
            r = sda_wire;
            n++;
            if (!r) begin
                scl <= 1'b0;
                wait_clk(6);
            end
        end
        // Start inside the high phase that showed SDA free; the next slot may be a zero
        sda_pull <= 1'b1;
        wait_clk(6);
        scl <= 1'b0;
        wait_clk(6);
    endtask
endmodule // tweep_ctl_model

// file: test/tweep_target_tb.sv
// Self-checking bench for the two-wire EEPROM target
`timescale 1ns/1ps
`include "tweep_defs.svh"
module tweep_target_tb;
    // Short write cycle, still longer than one poll attempt
    localparam int WR_CYC = 400;
    logic core_clk, arst_n, scl, pull, sda_out, sda_oe, busy;
    logic sda_out_4k, sda_oe_4k, busy_4k;
    logic [2:0] pins, sel;
    wire logic sda_wire;
    logic [7:0] mem [256];
    int num_errors = 0;
    int checked = 0;
    int seed = 37;
    // Pull-up wins unless someone pulls low
    assign sda_wire = !(sda_oe | sda_oe_4k | pull);
    tweep_target #(.VARIANT(`TWEEP_VAR_2K), .WR_CYCLES(WR_CYC)) tweep_target_i (
        .core_clk(core_clk), .arst_n(arst_n), .scl_in(scl), .sda_in(sda_wire),
        .sda_out(sda_out), .sda_oe(sda_oe), .select_pin_high(pins[2]),
        .select_pin_mid(pins[1]), .select_pin_low(pins[0]), .busy(busy));
    // Second part on the same bus: 4K sizing, upper straps opposite to the first
    tweep_target #(.VARIANT(`TWEEP_VAR_4K), .WR_CYCLES(WR_CYC)) tweep_target_4k_i (
        .core_clk(core_clk), .arst_n(arst_n), .scl_in(scl), .sda_in(sda_wire),
        .sda_out(sda_out_4k), .sda_oe(sda_oe_4k), .select_pin_high(!pins[2]),
        .select_pin_mid(!pins[1]), .select_pin_low(pins[0]), .busy(busy_4k));
    tweep_ctl_model tweep_ctl_model_i (
        .core_clk(core_clk), .sda_wire(sda_wire), .scl(scl), .sda_pull(pull));
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    // ==========================================
    // Checking and expectations
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        if (num_errors == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    function automatic logic [7:0] dev_word(input logic [2:0] p, input logic rw);
        return {`TWEEP_DEV_CODE, p, rw};
    endfunction
    function automatic logic [7:0] page_addr(input logic [7:0] base, input int i);
        return {base[7:3], base[2:0] + 3'(i)};
    endfunction
    // ==========================================
    // Transactions
    task automatic begin_op(input logic rw, input logic [7:0] word);
        logic ack;
        tweep_ctl_model_i.start();
        tweep_ctl_model_i.send_byte(dev_word(sel, rw), ack);
        check({7'h00, ack}, 8'h01);
        check({7'h00, sda_out | sda_out_4k}, 8'h00);
        if (!rw) begin
            tweep_ctl_model_i.send_byte(word, ack);
            check({7'h00, ack}, 8'h01);
        end
    endtask
    task automatic poll_ready();
        logic ack;
        int n;
        n = 0;
        do begin
            tweep_ctl_model_i.start();
            tweep_ctl_model_i.send_byte(dev_word(sel, 1'b0), ack);
            if (n == 0) check({7'h00, ack}, 8'h00);
            tweep_ctl_model_i.stop();
            n++;
        end while (!ack && n < 20);
        check({7'h00, ack}, 8'h01);
    endtask
    task automatic write_run(input logic [7:0] addr, input int n);
        logic ack;
        logic [7:0] d;
        begin_op(1'b0, addr);
        for (int i = 0; i < n; i++) begin
            d = 8'($random(seed));
            mem[page_addr(addr, i)] = d;
            tweep_ctl_model_i.send_byte(d, ack);
            check({7'h00, ack}, 8'h01);
        end
        tweep_ctl_model_i.stop();
        repeat (8) @(posedge core_clk);
        check({7'h00, (sel == pins) ? busy : busy_4k}, 8'h01);
        poll_ready();
    endtask
    task automatic read_run(input logic rand_rd, input logic [7:0] addr, input int n);
        logic [7:0] d;
        if (rand_rd) begin_op(1'b0, addr);
        begin_op(1'b1, 8'h00);
        for (int i = 0; i < n; i++) begin
            tweep_ctl_model_i.recv_byte(i < n - 1, d);
            check(d, mem[8'(addr + i)]);
        end
        tweep_ctl_model_i.stop();
    endtask
    // ==========================================
    // Main sequence
    initial begin
        logic ack;
        logic r;
        logic [7:0] a;
        logic [7:0] d0;
        arst_n = 1'b0;
        pins = 3'($random(seed));
        sel = pins;
        repeat (2) @(posedge core_clk);
        arst_n <= 1'b1;
        repeat (8) @(posedge core_clk);
        for (int i = 0; i < 4; i++) begin
            tweep_ctl_model_i.start();
            a = (i < 3) ? dev_word(pins ^ 3'(1 << i), 1'b1) : {4'h5, pins, 1'b1};
            tweep_ctl_model_i.send_byte(a, ack);
            check({7'h00, ack}, 8'h00);
            tweep_ctl_model_i.stop();
        end
        a = {5'($random(seed)), 3'h6};
        write_run(a, 10);
        read_run(1'b1, {a[7:3], 3'h0}, 8);
        write_run(8'hFE, 2);
        write_run(8'h00, 2);
        read_run(1'b1, 8'hFE, 3);
        read_run(1'b0, 8'h01, 1);
        for (int k = 0; k < 4; k++) begin
            a = 8'($random(seed));
            write_run(a, 1);
            read_run(1'b1, a, 1);
        end
        // Abandon a read mid-byte on a written address; target may be holding SDA low
        begin_op(1'b0, 8'hFE);
        begin_op(1'b1, 8'h00);
        for (int i = 0; i < 3; i++) tweep_ctl_model_i.xfer_bit(1'b1, r);
        tweep_ctl_model_i.recover();
        tweep_ctl_model_i.send_byte(dev_word(pins, 1'b1), ack);
        check({7'h00, ack}, 8'h01);
        tweep_ctl_model_i.recv_byte(1'b0, a);
        tweep_ctl_model_i.stop();
        read_run(1'b1, 8'hFF, 1);
        // 4K part: third device-word bit is a page bit, same word address
        sel = {~pins[2:1], 1'b0};
        write_run(8'h3C, 1);
        d0 = mem[8'h3C];
        sel[0] = 1'b1;
        write_run(8'h3C, 1);
        read_run(1'b1, 8'h3C, 1);
        sel[0] = 1'b0;
        mem[8'h3C] = d0;
        read_run(1'b1, 8'h3C, 1);
        wrap_up();
    end
    initial begin
        #400000;
        num_errors++;
        wrap_up();
    end
endmodule // tweep_target_tb
